// >>> common/lwpc_pkg.sv
// Package: offsets, field positions and reset values of the wake/control/status bank
`default_nettype none
package lwpc_pkg;
	// =====================================================================
	// Register indices (byte address is four times the index)
	localparam logic [5:0] IDX_WAKE_EVENT_INDICATION = 6'h1B;
	localparam logic [5:0] IDX_GENERAL_CONTROL = 6'h1C;
	localparam logic [5:0] IDX_GENERAL_STATUS = 6'h1D;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
	localparam logic [5:0] IDX_IRQ_CLEAR = 6'h21;
	localparam logic [5:0] IDX_IRQ_ENABLE = 6'h22;

	// =====================================================================
	// Wake indication fields
	localparam int WAKE_LINK_CHANGE_BIT = 7;
	localparam int WAKE_REMOTE_FRAME_BIT = 6;
	localparam int WAKE_FILTER_MATCH_BIT = 5;
	localparam int WAKE_EVENT_STATUS_BIT = 0;

	// =====================================================================
	// General control fields
	localparam int CTRL_LINK_IF_RESET_BIT = 3;
	localparam int CTRL_DEEP_PD_BIT = 1;

	// =====================================================================
	// General status fields
	localparam int STAT_DUPLEX_BIT = 2;
	localparam int STAT_SPEED_BIT = 1;
	localparam int STAT_LINK_BIT = 0;

	// =====================================================================
	// Interrupt status fields
	localparam int IRQ_WIDTH = 4;
	localparam int IRQ_LINK_CHANGE_BIT = 0;
	localparam int IRQ_REMOTE_FRAME_BIT = 1;
	localparam int IRQ_FILTER_MATCH_BIT = 2;
	localparam int IRQ_EVENT_STATUS_BIT = 3;

	// =====================================================================
	// Reset values and power states
	localparam logic [7:0] WAKE_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 4'h0;
	localparam logic [1:0] PSTATE_D2 = 2'h2;
	localparam logic [1:0] PSTATE_D3 = 2'h3;
endpackage
`default_nettype wire

// >>> hdl/lwpc_regs.sv
// Wake indication, general control and general status registers on classic Wishbone
//
// The Wishbone interface to the registers is this design's own decision.
`default_nettype none
module lwpc_regs
#(
	parameter int BUS_WIDTH = 32
)
(
	input wire logic clk_sys,
	input wire logic arst_n,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [BUS_WIDTH/8-1:0] wb_sel_i,
	input wire logic [BUS_WIDTH-1:0] wb_dat_i,
	output logic [BUS_WIDTH-1:0] wb_dat_o,
	output logic wb_ack_o,
	// Link and frame inputs
	input wire logic link_valid,
	input wire logic link_full_duplex,
	input wire logic link_speed_100,
	input wire logic remote_wake_frame,
	input wire logic filter_match_frame,
	// Power management context
	input wire logic event_enable,
	input wire logic event_status_clear,
	input wire logic [1:0] power_state,
	// Outputs
	output logic power_event_signal,
	output logic event_status,
	output logic link_if_reset,
	output logic deep_power_down,
	output logic irq
);

	// =====================================================================
	// Reset release
	logic [1:0] rst_sync;
	logic rst_n;

	// Both flops clear at once; release comes two edges later
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end

	assign rst_n = rst_sync[1];

	// =====================================================================
	// Bus decode
	// Word index only; byte offsets inside a word alias
	function automatic logic hit(input logic [7:0] adr, input logic [5:0] idx);
		hit = (adr[7:2] == idx);
	endfunction

	// Write-one-to-clear strobe for one bit of the written word
	function automatic logic w1c(input logic strobe, input logic [BUS_WIDTH-1:0] data,
		input int pos);
		w1c = strobe && data[pos];
	endfunction

	// One select per register, used by the write strobes, the read mux or both
	logic at_wake;
	logic at_ctrl;
	logic at_stat;
	logic at_irq_stat;
	logic at_irq_clr;
	logic at_irq_en;

	assign at_wake = hit(wb_adr_i, lwpc_pkg::IDX_WAKE_EVENT_INDICATION);
	assign at_ctrl = hit(wb_adr_i, lwpc_pkg::IDX_GENERAL_CONTROL);
	assign at_stat = hit(wb_adr_i, lwpc_pkg::IDX_GENERAL_STATUS);
	assign at_irq_stat = hit(wb_adr_i, lwpc_pkg::IDX_IRQ_STATUS);
	assign at_irq_clr = hit(wb_adr_i, lwpc_pkg::IDX_IRQ_CLEAR);
	assign at_irq_en = hit(wb_adr_i, lwpc_pkg::IDX_IRQ_ENABLE);

	logic req;
	logic wr;
	logic wr_wake;
	logic wr_ctrl;
	logic wr_irq_clr;
	logic wr_irq_en;

	// Ack low in the taken cycle, so a held strobe is taken every other cycle
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Registers are 8 bits wide, so only lane 0 carries a write
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign wr_wake = wr && at_wake;
	assign wr_ctrl = wr && at_ctrl;
	assign wr_irq_clr = wr && at_irq_clr;
	assign wr_irq_en = wr && at_irq_en;

	// =====================================================================
	// Link change detection
	logic link_prev;
	logic link_primed;
	logic link_change;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			link_prev <= 1'b0;
			link_primed <= 1'b0;
		end
		else
		begin
			link_prev <= link_valid;
			link_primed <= 1'b1;
		end
	end

	// No previous sample right after reset, so no false change then
	assign link_change = link_primed && (link_valid != link_prev);

	// =====================================================================
	// Wake indication bits; a set in the same cycle as a clear wins
	logic wake_link;
	logic wake_remote;
	logic wake_filter;
	logic any_wake;

	assign any_wake = link_change || remote_wake_frame || filter_match_frame;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			wake_link <= lwpc_pkg::WAKE_RESET[lwpc_pkg::WAKE_LINK_CHANGE_BIT];
		else if (link_change)
			wake_link <= 1'b1;
		else if (w1c(wr_wake, wb_dat_i, lwpc_pkg::WAKE_LINK_CHANGE_BIT))
			wake_link <= 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			wake_remote <= lwpc_pkg::WAKE_RESET[lwpc_pkg::WAKE_REMOTE_FRAME_BIT];
		else if (remote_wake_frame)
			wake_remote <= 1'b1;
		else if (w1c(wr_wake, wb_dat_i, lwpc_pkg::WAKE_REMOTE_FRAME_BIT))
			wake_remote <= 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			wake_filter <= lwpc_pkg::WAKE_RESET[lwpc_pkg::WAKE_FILTER_MATCH_BIT];
		else if (filter_match_frame)
			wake_filter <= 1'b1;
		else if (w1c(wr_wake, wb_dat_i, lwpc_pkg::WAKE_FILTER_MATCH_BIT))
			wake_filter <= 1'b0;
	end

	// =====================================================================
	// Event status, shared with the power control/status register
	logic next_event_status;

	always_comb
	begin
		next_event_status = event_status;
		if (any_wake)
			next_event_status = 1'b1;
		else if (w1c(wr_wake, wb_dat_i, lwpc_pkg::WAKE_EVENT_STATUS_BIT) || event_status_clear)
			next_event_status = 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			event_status <= lwpc_pkg::WAKE_RESET[lwpc_pkg::WAKE_EVENT_STATUS_BIT];
		else
			event_status <= next_event_status;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			power_event_signal <= 1'b0;
		else
			power_event_signal <= next_event_status && event_enable;
	end

	// =====================================================================
	// General control; reserved bits are not stored
	logic ctrl_link_reset;
	logic ctrl_deep_pd;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_link_reset <= lwpc_pkg::CTRL_RESET[lwpc_pkg::CTRL_LINK_IF_RESET_BIT];
			ctrl_deep_pd <= lwpc_pkg::CTRL_RESET[lwpc_pkg::CTRL_DEEP_PD_BIT];
		end
		else if (wr_ctrl)
		begin
			ctrl_link_reset <= wb_dat_i[lwpc_pkg::CTRL_LINK_IF_RESET_BIT];
			ctrl_deep_pd <= wb_dat_i[lwpc_pkg::CTRL_DEEP_PD_BIT];
		end
	end

	// Link interface reset follows the control bit one cycle later
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			link_if_reset <= 1'b0;
		else
			link_if_reset <= ctrl_link_reset;
	end

	// Permission only; the power sequencer decides when to enter the state
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			deep_power_down <= 1'b0;
		else
			deep_power_down <= ctrl_deep_pd && !link_valid &&
				(power_state == lwpc_pkg::PSTATE_D2 || power_state == lwpc_pkg::PSTATE_D3);
	end

	// =====================================================================
	// Interrupt status, clear and enable
	logic [lwpc_pkg::IRQ_WIDTH-1:0] irq_events;
	logic [lwpc_pkg::IRQ_WIDTH-1:0] irq_status;
	logic [lwpc_pkg::IRQ_WIDTH-1:0] irq_enable;
	logic event_rise;

	// Rising edge only, so a status held high raises one interrupt
	assign event_rise = next_event_status && !event_status;
	assign irq_events[lwpc_pkg::IRQ_LINK_CHANGE_BIT] = link_change;
	assign irq_events[lwpc_pkg::IRQ_REMOTE_FRAME_BIT] = remote_wake_frame;
	assign irq_events[lwpc_pkg::IRQ_FILTER_MATCH_BIT] = filter_match_frame;
	assign irq_events[lwpc_pkg::IRQ_EVENT_STATUS_BIT] = event_rise;

	// Set wins, so an event in the clear cycle is kept
	genvar gi;
	generate
		for (gi = 0; gi < lwpc_pkg::IRQ_WIDTH; gi++)
		begin : g_irq
			always_ff @(posedge clk_sys or negedge rst_n)
			begin
				if (!rst_n)
					irq_status[gi] <= lwpc_pkg::IRQ_RESET[gi];
				else if (irq_events[gi])
					irq_status[gi] <= 1'b1;
				else if (w1c(wr_irq_clr, wb_dat_i, gi))
					irq_status[gi] <= 1'b0;
			end
		end
	endgenerate

	// Enable reads back so software can save and restore it
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			irq_enable <= lwpc_pkg::IRQ_RESET;
		else if (wr_irq_en)
			irq_enable <= wb_dat_i[lwpc_pkg::IRQ_WIDTH-1:0];
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(irq_status & irq_enable);
	end

	// =====================================================================
	// Read data and acknowledge
	logic [7:0] rd_byte;

	always_comb
	begin
		rd_byte = 8'h00;
		if (at_wake)
		begin
			rd_byte[lwpc_pkg::WAKE_LINK_CHANGE_BIT] = wake_link;
			rd_byte[lwpc_pkg::WAKE_REMOTE_FRAME_BIT] = wake_remote;
			rd_byte[lwpc_pkg::WAKE_FILTER_MATCH_BIT] = wake_filter;
			rd_byte[lwpc_pkg::WAKE_EVENT_STATUS_BIT] = event_status;
		end
		else if (at_ctrl)
		begin
			rd_byte[lwpc_pkg::CTRL_LINK_IF_RESET_BIT] = ctrl_link_reset;
			rd_byte[lwpc_pkg::CTRL_DEEP_PD_BIT] = ctrl_deep_pd;
		end
		else if (at_stat)
		begin
			rd_byte[lwpc_pkg::STAT_DUPLEX_BIT] = link_full_duplex;
			rd_byte[lwpc_pkg::STAT_SPEED_BIT] = link_speed_100;
			rd_byte[lwpc_pkg::STAT_LINK_BIT] = link_valid;
		end
		else if (at_irq_stat)
			rd_byte[lwpc_pkg::IRQ_WIDTH-1:0] = irq_status;
		else if (at_irq_en)
			rd_byte[lwpc_pkg::IRQ_WIDTH-1:0] = irq_enable;
	end

	// Every address answers; unmapped ones read zero and ignore writes
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= req;
	end

	// Read data holds between reads; writes leave it alone
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			wb_dat_o <= {BUS_WIDTH{1'b0}};
		else if (req && !wb_we_i)
			wb_dat_o <= {{(BUS_WIDTH-8){1'b0}}, rd_byte};
	end

endmodule
`default_nettype wire

// >>> tb/lwpc_phy_model.sv
// Far-side model: link partner and frame source
`default_nettype none
module lwpc_phy_model
(
	input wire logic link_if_reset,
	input wire logic link_req,
	input wire logic dup_req,
	input wire logic spd_req,
	input wire logic rw_req,
	input wire logic fm_req,
	output logic link_valid,
	output logic link_full_duplex,
	output logic link_speed_100,
	output logic remote_wake_frame,
	output logic filter_match_frame
);
	// Held in reset: no link and no frames
	assign link_valid = link_req && !link_if_reset;
	assign link_full_duplex = dup_req;
	assign link_speed_100 = spd_req;
	assign remote_wake_frame = rw_req && !link_if_reset;
	assign filter_match_frame = fm_req && !link_if_reset;
endmodule
`default_nettype wire

// >>> tb/lwpc_props.sv
// Checker: bus, event and power output properties of the register bank
`default_nettype none
module lwpc_props
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic link_valid,
	input wire logic link_full_duplex,
	input wire logic link_speed_100,
	input wire logic remote_wake_frame,
	input wire logic filter_match_frame,
	input wire logic event_enable,
	input wire logic [1:0] power_state,
	input wire logic power_event_signal,
	input wire logic event_status,
	input wire logic link_if_reset,
	input wire logic deep_power_down
);
	logic tk;
	logic wr0;
	assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr0 = tk && wb_we_i && wb_sel_i[0];
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	// =========================================================
	// Bus and register properties
	AST_ACK_NEXT: assert property (tk |=> wb_ack_o)
		else $error("ack missing");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	AST_STATUS_READ: assert property (tk && !wb_we_i && wb_adr_i == 8'h74 |=>
		wb_dat_o == {29'h0, $past(link_full_duplex), $past(link_speed_100), $past(link_valid)})
		else $error("status read wrong");
	AST_LINK_RESET: assert property (wr0 && wb_adr_i == 8'h70 |=> ##1
		link_if_reset == $past(wb_dat_i[3], 2)) else $error("link reset wrong");
	// =========================================================
	// Event and power properties
	AST_REMOTE_EVENT: assert property (remote_wake_frame |=> event_status)
		else $error("remote frame lost");
	AST_FILTER_EVENT: assert property (filter_match_frame |=> event_status)
		else $error("filter match lost");
	AST_EVENT_OUT: assert property (power_event_signal |-> event_status && $past(event_enable))
		else $error("event output wrong");
	AST_W1C_EVENT: assert property (wr0 && wb_adr_i == 8'h6C && wb_dat_i[0] && $stable(link_valid)
		&& !remote_wake_frame && !filter_match_frame |=> !event_status) else $error("no clear");
	AST_DEEP_PD: assert property (deep_power_down |-> !$past(link_valid) && $past(power_state) >= 2'h2)
		else $error("deep power-down wrong");
endmodule
bind lwpc_regs lwpc_props u_props (.*);
`default_nettype wire

// >>> tb/tb_top.sv
// Testbench: register bank driven over Wishbone with a far-side model
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
	$display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
	logic link_valid, link_full_duplex, link_speed_100, remote_wake_frame, filter_match_frame;
	logic event_enable, event_status_clear, power_event_signal, event_status;
	logic link_if_reset, deep_power_down, link_req, dup_req, spd_req, rw_req, fm_req;
	logic [7:0] wb_adr_i, b;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, e_now;
	logic [1:0] power_state;
	logic [31:0] exp_q[$];
	int fail_count, n_compared, i;
	// Stand-in for the 1 ms settle time, kept short
	localparam int LINK_WAIT = 16;
	lwpc_regs u_dut (.*);
	lwpc_phy_model u_phy (.link_if_reset(link_if_reset), .link_req(link_req),
		.dup_req(dup_req), .spd_req(spd_req), .rw_req(rw_req), .fm_req(fm_req),
		.link_valid(link_valid), .link_full_duplex(link_full_duplex),
		.link_speed_100(link_speed_100), .remote_wake_frame(remote_wake_frame),
		.filter_match_frame(filter_match_frame));
	// =========================================================
	// Clock, bus tasks and result monitor
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic report_and_stop;
		if (fail_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h000000, d};
		do
			@(posedge clk_sys);
		while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back({24'h000000, e});
		bus(1'b0, a, 8'h00);
	endtask
	// Toggle link, or pulse a frame for one cycle
	task automatic ev(input int s);
		@(posedge clk_sys);
		if (s == 0)
			link_req <= ~link_req;
		else if (s == 1)
			rw_req <= 1'b1;
		else
			fm_req <= 1'b1;
		@(posedge clk_sys);
		rw_req <= 1'b0;
		fm_req <= 1'b0;
		tick(3);
	endtask
	always @(posedge clk_sys)
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
		begin
			e_now = exp_q.pop_front();
			`CHK(wb_dat_o, e_now)
		end
	initial
	begin
		tick(20000);
		fail_count++;
		report_and_stop;
	end
	// =========================================================
	// Main sequence
	initial
	begin
		{arst_n, wb_cyc_i, wb_stb_i, wb_we_i, event_enable, event_status_clear} = 6'h00;
		{link_req, dup_req, spd_req, rw_req, fm_req} = 5'h00;
		{wb_adr_i, wb_dat_i, power_state} = 42'h0;
		wb_sel_i = 4'hF;
		void'($urandom(50796));
		tick(4);
		arst_n <= 1'b1;
		tick(3);
		rd(8'h6C, 8'h00);
		rd(8'h70, 8'h00);
		wb_sel_i <= 4'hE;
		bus(1'b1, 8'h70, 8'hFF);
		wb_sel_i <= 4'hF;
		rd(8'h70, 8'h00);
		for (i = 0; i < 6; i++)
		begin
			b = 8'($urandom());
			{dup_req, spd_req, link_req} <= b[2:0];
			tick(2);
			rd(8'h74, {5'h00, b[2:0]});
		end
		bus(1'b1, 8'h6C, 8'hFF);
		bus(1'b1, 8'h84, 8'h0F);
		rd(8'h6C, 8'h00);
		for (i = 0; i < 3; i++)
		begin
			ev(i);
			`CHK(power_event_signal, 1'b0)
			`CHK(event_status, 1'b1)
			rd(8'h6C, 8'h01 | (8'h80 >> i));
			bus(1'b1, 8'h6C, 8'h1E);
			rd(8'h6C, 8'h01 | (8'h80 >> i));
			bus(1'b1, 8'h6C, 8'h80 >> i);
			rd(8'h6C, 8'h01);
			bus(1'b1, 8'h6C, 8'h01);
			tick(1);
			`CHK(event_status, 1'b0)
		end
		bus(1'b1, 8'h84, 8'h0F);
		bus(1'b1, 8'h88, 8'h02);
		rd(8'h88, 8'h02);
		ev(2);
		`CHK(irq, 1'b0)
		ev(1);
		`CHK(irq, 1'b1)
		bus(1'b1, 8'h84, 8'h02);
		tick(2);
		`CHK(irq, 1'b0)
		rd(8'hFC, 8'h00);
		event_enable <= 1'b1;
		ev(1);
		`CHK(power_event_signal, 1'b1)
		event_status_clear <= 1'b1;
		tick(1);
		event_status_clear <= 1'b0;
		tick(2);
		`CHK(power_event_signal, 1'b0)
		rd(8'h6C, 8'h60);
		ev(2);
		bus(1'b1, 8'h6C, 8'h01);
		tick(1);
		`CHK(power_event_signal, 1'b0)
		bus(1'b1, 8'h70, 8'hFF);
		rd(8'h70, 8'h0A);
		`CHK(link_if_reset, 1'b1)
		for (i = 0; i < 4; i++)
		begin
			power_state <= 2'(i);
			tick(3);
			`CHK(deep_power_down, 1'(i > 1))
		end
		// Reserved bits zero, deep power-down and link interface reset turned off
		bus(1'b1, 8'h70, 8'h00);
		tick(LINK_WAIT);
		`CHK(link_if_reset, 1'b0)
		link_req <= 1'b1;
		bus(1'b1, 8'h70, 8'h02);
		tick(3);
		`CHK(deep_power_down, 1'b0)
		link_req <= 1'b0;
		tick(3);
		`CHK(deep_power_down, 1'b1)
		`CHK(exp_q.size(), 0)
		report_and_stop;
	end
endmodule
`default_nettype wire
